/* rtl/acbpp_port.sv */
`timescale 1ns/1ps
`include "acbpp_params.svh"
module acbpp_port import acbpp_pkg::*; #(
   parameter logic [7:0] IDENT_CODE = 8'h5a, // arbitrary identity value
   parameter logic [2:0] FIXED_SEL = 3'h0 // hard-wired select bits
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // backplane hard reset
   input wire acbpp_pins_s pins, // backplane and pacing pins
   input wire logic [4:0] select_switch, // switch-set select bits
   input wire logic [1:0] int_level, // interrupt level straps
   input wire logic [15:0] data_in, // backplane data from host
   input wire logic [13:0] adc_result, // buffered converter result
   output logic [15:0] data_out, // backplane data to host
   output logic [1:0] data_oe_n, // lane drive, low drives {upper,lower}
   output logic backplane_ack_n, // transfer acknowledge
   output logic selected_indicator_n, // card addressed
   output logic [1:0] gain_sel, // gain multiplexer drive
   output logic [2:0] chan_sel, // channel multiplexer drive
   output logic [7:0] reg_strobe_n, // register decoder outputs
   output logic [4:0] conv_cycle, // conversion counter
   output logic pace_window, // counter may be stopped
   output logic irq_enable // interrupt enable flop
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   acbpp_pins_s sp_x;
   acbpp_pins_s sp;
   logic [7:0] sw_s;
   // stored relative to the idle levels, so a freshly reset stage
   // reads as an idle bus and never as an active strobe
   acbpp_sync #(.WIDTH($bits(acbpp_pins_s))) u_sync_pins (
      .clk(clk),
      .rst_n(rst_n),
      .d(pins ^ `ACBPP_PINS_IDLE),
      .q(sp_x)
   );
   assign sp = sp_x ^ `ACBPP_PINS_IDLE;
   acbpp_sync #(.WIDTH(8)) u_sync_straps (
      .clk(clk),
      .rst_n(rst_n),
      .d({select_switch, int_level, 1'b0}),
      .q(sw_s)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire sel_match = (sp.addr[23:16] == {FIXED_SEL, sw_s[7:3]});
   wire card_selected_n = ~(sel_match & ~sp.addr_strobe_n);
   wire access_request = ~card_selected_n &
      ~(sp.upper_byte_strobe_n & sp.lower_byte_strobe_n);
   wire analog_read_flag = sp.addr[6] & ~card_selected_n;
   wire [2:0] reg_index = sp.addr[3:1];
   wire rd = sp.read_not_write;
   wire analog_out_en_n = ~(rd & analog_read_flag);
   wire ident_out_en_n = ~(rd & ~analog_read_flag & reg_index == `ACBPP_ID_OFFSET);
   wire status_out_en_n = ~(rd & ~analog_read_flag & reg_index == `ACBPP_STATUS_OFFSET);

   // ----------------------------------------
   // handshake
   // ----------------------------------------
   logic hs1_q, hs2_q, hs2_d;
   assign hs2_d = access_request & hs1_q;
   wire transfer_ack_n = ~hs2_q;
   // request low clears both flops at once; kept synchronous to
   // avoid a logic-driven async clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs1_q <= 1'b0;
         hs2_q <= 1'b0;
      end else begin
         hs1_q <= access_request;
         hs2_q <= hs2_d;
      end
   end
   wire ack_edge = hs2_d & ~hs2_q;
   wire write_pulse = ack_edge & ~rd;
   wire soft_clear_n = ~(write_pulse & ~analog_read_flag &
      reg_index == `ACBPP_ID_OFFSET);
   wire status_write = write_pulse & ~analog_read_flag &
      reg_index == `ACBPP_STATUS_OFFSET;

   // ----------------------------------------
   // busy machine and address stages
   // ----------------------------------------
   acbpp_busy_e busy_q, busy_d;
   logic [5:1] addr_capture_q, mux_q;
   logic [4:0] cnt_q, cnt_d;
   wire busy = (busy_q == ACBPP_BUSY);
   wire wait_state = (cnt_q == `ACBPP_CYC_WAIT);
   always_comb begin
      busy_d = busy_q;
      unique case (busy_q)
         ACBPP_IDLE: if (ack_edge & analog_read_flag) busy_d = ACBPP_GRAB;
         ACBPP_GRAB: if (!access_request) busy_d = ACBPP_BUSY;
         ACBPP_BUSY: if (cnt_q == `ACBPP_CYC_LATCH) busy_d = ACBPP_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= ACBPP_IDLE;
         addr_capture_q <= 5'h00;
      end else if (!soft_clear_n) begin
         busy_q <= ACBPP_IDLE;
         addr_capture_q <= 5'h00;
      end else begin
         busy_q <= busy_d;
         // analog writes also land here and overwrite the pipeline
         if (busy_q == ACBPP_IDLE && busy_d == ACBPP_GRAB)
            addr_capture_q <= sp.addr[5:1];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mux_q <= 5'h00;
      else if (cnt_q == `ACBPP_CYC_STAGE2 && cnt_d != cnt_q) mux_q <= addr_capture_q;
   end

   // ----------------------------------------
   // conversion counter gate
   // ----------------------------------------
   wire ext_pace_hold_n = ~sp.ext_pace_in;
   wire pace_timer_allow = ~sp.int_pace_disable_in;
   // soft clear lands on the same edge as the counter; the mirrors follow it
   wire [4:0] cnt_nx = soft_clear_n ? cnt_d : `ACBPP_CYC_WAIT;
   wire window_d = (cnt_nx >= `ACBPP_CYC_WINDOW);
   wire pace_stop = (cnt_q == `ACBPP_CYC_PARK) &
      (~ext_pace_hold_n | (pace_timer_allow & sp.pace_timer_running));
   wire wait_stop = wait_state & ~busy;
   always_comb begin
      cnt_d = cnt_q;
      if (!(pace_stop | wait_stop))
         cnt_d = (cnt_q == `ACBPP_CYC_LAST) ? `ACBPP_CYC_WAIT : 5'(cnt_q + 5'h01);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= `ACBPP_CYC_WAIT;
      else if (!soft_clear_n) cnt_q <= `ACBPP_CYC_WAIT;
      else cnt_q <= cnt_d;
   end

   // ----------------------------------------
   // read data and outputs
   // ----------------------------------------
   wire [15:0] status_word = {8'h00, irq_enable, ~busy, sw_s[2:1], 4'h0};
   wire [15:0] ana_word = {busy, wait_state, adc_result};
   wire [15:0] rd_word = !analog_out_en_n ? ana_word :
      !ident_out_en_n ? {8'h00, IDENT_CODE} :
      !status_out_en_n ? status_word : 16'h0000;
   wire [1:0] lane_n = {sp.upper_byte_strobe_n, sp.lower_byte_strobe_n};
   wire [7:0] dec_n = (analog_read_flag | card_selected_n) ? 8'hff :
      ~(8'h01 << reg_index);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= 16'h0000;
         data_oe_n <= 2'h3;
         backplane_ack_n <= 1'b1;
         selected_indicator_n <= 1'b1;
         gain_sel <= 2'h0;
         chan_sel <= 3'h0;
         reg_strobe_n <= 8'hff;
         conv_cycle <= 5'h00;
         pace_window <= 1'b0;
         irq_enable <= `ACBPP_RESET_IRQEN;
      end else begin
         data_out <= rd_word;
         data_oe_n <= (card_selected_n | ~rd) ? 2'h3 : lane_n;
         backplane_ack_n <= ~hs2_d;
         selected_indicator_n <= card_selected_n;
         gain_sel <= mux_q[5:4];
         chan_sel <= mux_q[3:1];
         reg_strobe_n <= dec_n;
         conv_cycle <= cnt_nx;
         pace_window <= window_d;
         if (status_write) irq_enable <= data_in[`ACBPP_ST_IRQEN_BIT];
      end
   end
   wire unused_ok = &{transfer_ack_n, sw_s[0], data_in[15:8], data_in[6:0]};
endmodule // acbpp_port

/* rtl/acbpp_params.svh */
// Contract
// - stop counter at park while hold high
// - held pace: busy shows, parked at 16
// - timer disallowed never stops the counter
// - select code compare gates card selection
// - two-flop acknowledge after access request
// - request fall clears both handshake flops
// - only address bits one to six decode
// - bit six raises analog read flag
// - gain bits pass two buffer stages
// - channel bits buffered, else register decode
// - hard reset clears enable, counter zero
// - write to address one soft resets
// - data lanes follow direction and strobes
// - read drives analog, identity or status
// - busy on data bit 15, inverse status 6
// - interrupt enable at status bit 7
`ifndef ACBPP_PARAMS_SVH
`define ACBPP_PARAMS_SVH
// ----------------------------------------
// register decode (a3..a1)
// ----------------------------------------
`define ACBPP_ID_OFFSET 3'h1
`define ACBPP_STATUS_OFFSET 3'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACBPP_ANA_BUSY_BIT 15
`define ACBPP_ANA_WAIT_BIT 14
`define ACBPP_ST_IRQEN_BIT 7
`define ACBPP_ST_NBUSY_BIT 6
`define ACBPP_RESET_IRQEN 1'b0
// ----------------------------------------
// conversion cycle points
// ----------------------------------------
`define ACBPP_CYC_WAIT 5'h00
`define ACBPP_CYC_STAGE2 5'h02
`define ACBPP_CYC_LATCH 5'h04
`define ACBPP_CYC_WINDOW 5'h0f
`define ACBPP_CYC_PARK 5'h10
`define ACBPP_CYC_LAST 5'h1d
`define ACBPP_SYNC_STAGES 2
// idle pin levels: strobes high, read, pacing inputs low
`define ACBPP_PINS_IDLE {23'h000000, 4'hf, 3'h0}
`endif

/* rtl/acbpp_pkg.sv */
package acbpp_pkg;
   typedef struct packed {
      logic [23:1] addr;
      logic addr_strobe_n;
      logic upper_byte_strobe_n;
      logic lower_byte_strobe_n;
      logic read_not_write;
      logic ext_pace_in;
      logic int_pace_disable_in;
      logic pace_timer_running;
   } acbpp_pins_s;
   typedef enum logic [2:0] {
      ACBPP_IDLE = 3'b001,
      ACBPP_GRAB = 3'b010,
      ACBPP_BUSY = 3'b100
   } acbpp_busy_e;
endpackage

/* rtl/acbpp_sync.sv */
`timescale 1ns/1ps
`include "acbpp_params.svh"
module acbpp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset
   input wire logic [WIDTH-1:0] d, // asynchronous level
   output logic [WIDTH-1:0] q // synchronised level
);
   logic [WIDTH-1:0] meta_q;
   // first stage read only by second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // acbpp_sync

/* bench/acbpp_properties.sv */
`timescale 1ns/1ps
module acbpp_props import acbpp_pkg::*; (
   input wire logic clk, // system clock
   input wire logic rst_n, // hard reset
   input wire acbpp_pins_s pins, // backplane pins
   input wire logic [1:0] data_oe_n, // lane drive
   input wire logic backplane_ack_n, // acknowledge
   input wire logic selected_indicator_n, // card selected
   input wire logic [7:0] reg_strobe_n, // register decoder
   input wire logic [4:0] conv_cycle, // counter
   input wire logic pace_window, // window flag
   input wire logic irq_enable // enable flop
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // --------------------------------
   // pins lag two sync edges, hence 4-5 cycle windows
   // --------------------------------
   AST_HOLD: assert property ((pins.ext_pace_in && pins.addr_strobe_n) [*4]
      ##0 conv_cycle == 5'h10 |=> conv_cycle == 5'h10) else $error("counter left park");
   AST_SEL: assert property ((pins.addr[23:21] != 3'h0) [*4]
      |-> selected_indicator_n && backplane_ack_n) else $error("foreign code selected");
   AST_ACK: assert property ($fell(backplane_ack_n)
      |-> !selected_indicator_n && $past(!pins.addr_strobe_n, 3)) else $error("early ack");
   AST_REL: assert property ((pins.upper_byte_strobe_n && pins.lower_byte_strobe_n) [*5]
      |-> backplane_ack_n) else $error("ack not cleared");
   AST_LANE: assert property (pins.upper_byte_strobe_n [*5] |-> data_oe_n[1])
      else $error("upper lane driven");
   AST_DIR: assert property ((!pins.read_not_write) [*5] |-> &data_oe_n)
      else $error("lanes driven on write");
   AST_DEC: assert property ($onehot0(~reg_strobe_n)) else $error("two strobes");
   AST_ANA: assert property (pins.addr[6] [*5] |-> &reg_strobe_n)
      else $error("decoder active on analog read");
   AST_HRST: assert property ($rose(rst_n) |-> conv_cycle == 5'h00 && !irq_enable)
      else $error("hard reset state wrong");
   AST_WIN: assert property (pace_window == (conv_cycle >= 5'h0f))
      else $error("window flag off");
endmodule // acbpp_props
bind acbpp_port acbpp_props acbpp_props_i (.clk, .rst_n, .pins, .data_oe_n,
   .backplane_ack_n, .selected_indicator_n, .reg_strobe_n, .conv_cycle, .pace_window,
   .irq_enable);

/* bench/acbpp_host.sv */
`timescale 1ns/1ps
module acbpp_host import acbpp_pkg::*; (
   input wire logic clk, // system clock
   input wire logic ack_n, // device acknowledge
   input wire logic [15:0] dout, // device read data
   input wire logic ep, // external pace level
   input wire logic ipd, // timer disable level
   input wire logic ptr, // timer still counting
   output acbpp_pins_s pins, // backplane and pacing pins
   output logic [15:0] wdata // write data
);
   acbpp_pins_s b;
   initial begin
      b = '1;
      wdata = '0;
   end
   always_comb begin
      pins = b;
      pins.ext_pace_in = ep;
      pins.int_pace_disable_in = ipd;
      pins.pace_timer_running = ptr;
   end
   task automatic cyc(input logic [23:1] a, input logic r, input logic [15:0] wd,
      output logic [15:0] rd, output logic ok);
      ok = 1'b0;
      b.addr = a;
      b.read_not_write = r | a[6];
      wdata = wd;
      {b.addr_strobe_n, b.upper_byte_strobe_n, b.lower_byte_strobe_n} = 3'b000;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         ok = (ack_n === 1'b0);
      end
      rd = dout;
      #1;
      // released lines show the inverse, not a stale copy
      b.addr = ~a;
      {b.addr_strobe_n, b.upper_byte_strobe_n, b.lower_byte_strobe_n} = 3'b111;
      wdata = ~wd;
      for (int n = 0; n < 20 && ack_n !== 1'b1; n++) @(posedge clk);
      ok = ok & (ack_n === 1'b1);
      #1;
   endtask
endmodule // acbpp_host

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top import acbpp_pkg::*; ;
   logic clk = 0, rst_n = 0, ep = 0, ipd = 0, ptr = 1, ok;
   acbpp_pins_s pins;
   logic [4:0] select_switch = 5'h0b, conv_cycle;
   logic [1:0] int_level = 2'h2, data_oe_n, gain_sel;
   logic [15:0] data_in, data_out, rd;
   logic [13:0] adc_result = 14'h2a5c;
   logic backplane_ack_n, selected_indicator_n, pace_window, irq_enable;
   logic [2:0] chan_sel;
   logic [7:0] reg_strobe_n;
   int failures = 0, n_checks = 0;
   always #5 clk = ~clk;
   acbpp_port acbpp_port_i (.clk, .rst_n, .pins, .select_switch, .int_level, .data_in,
      .adc_result, .data_out, .data_oe_n, .backplane_ack_n, .selected_indicator_n,
      .gain_sel, .chan_sel, .reg_strobe_n, .conv_cycle, .pace_window, .irq_enable);
   acbpp_host acbpp_host_i (.clk, .ack_n(backplane_ack_n), .dout(data_out), .ep, .ipd,
      .ptr, .pins, .wdata(data_in));
   // --------------------------------
   // helpers
   // --------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task rw(input logic [5:0] x, input logic r, input logic [15:0] wd);
      acbpp_host_i.cyc({8'h0b, 9'h000, x}, r, wd, rd, ok);
      chk(ok, 1'b1);
   endtask
   // bounded wait for a counter value; a miss ends the run
   task wc(input logic [4:0] v);
      for (int n = 0; n < 300 && conv_cycle !== v; n++) step(1);
      chk(conv_cycle, v);
      if (conv_cycle !== v) test_done();
   endtask
   // --------------------------------
   // scenarios
   // --------------------------------
   task t_regs;
      chk(conv_cycle, 5'h00);
      chk(irq_enable, 1'b0);
      rw(6'h01, 1'b1, 16'h0000);
      chk(rd, 16'h005a);
      rw(6'h03, 1'b0, 16'h0080);
      chk(irq_enable, 1'b1);
      rw(6'h03, 1'b1, 16'h0000);
      chk(rd[7:4], 4'he);
      acbpp_host_i.cyc({8'h4b, 15'h0003}, 1'b1, 16'h0000, rd, ok);
      chk(ok, 1'b0);
   endtask
   task t_pace;
      ep = 1'b1;
      ipd = 1'b1;
      rw(6'h20, 1'b1, 16'h0000);
      wc(5'h10);
      step(6);
      chk(conv_cycle, 5'h10);
      chk(pace_window, 1'b1);
      rw(6'h35, 1'b1, 16'h0000);
      rw(6'h20, 1'b1, 16'h0000);
      chk(rd, {2'b10, adc_result});
      rw(6'h03, 1'b1, 16'h0000);
      chk(rd[6], 1'b0);
      ep = 1'b0;
      wc(5'h05);
      chk(gain_sel, 2'b10);
      chk(chan_sel, 3'h5);
      // timer still running but disallowed: must pass the park point
      wc(5'h11);
      ipd = 1'b0;
      rw(6'h20, 1'b1, 16'h0000);
      wc(5'h10);
      step(6);
      chk(conv_cycle, 5'h10);
      ptr = 1'b0;
      wc(5'h11);
      ptr = 1'b1;
      ipd = 1'b1;
      ep = 1'b1;
      rw(6'h20, 1'b1, 16'h0000);
      wc(5'h10);
      rw(6'h20, 1'b1, 16'h0000);
      rw(6'h01, 1'b0, 16'h0000);
      wc(5'h00);
      step(5);
      chk(conv_cycle, 5'h00);
      chk(pace_window, 1'b0);
      chk(irq_enable, 1'b1);
      rw(6'h03, 1'b1, 16'h0000);
      chk(rd[6], 1'b1);
   endtask
   // hard reset in mid-run, then a clean transfer
   task t_hrst;
      rw(6'h20, 1'b1, 16'h0000);
      wc(5'h08);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      step(1);
      chk(conv_cycle, 5'h00);
      chk(irq_enable, 1'b0);
      rw(6'h01, 1'b1, 16'h0000);
      chk(rd, 16'h005a);
   endtask
   initial begin
      step(2);
      rst_n = 1'b1;
      step(1);
      t_regs();
      t_pace();
      t_hrst();
      test_done();
   end
endmodule // tb_top
